// >>> core/iap_flash_defines.vh
// Operation
// RULE1 - Flash reads happen only while read permitted
// RULE2 - Read start bit self-clears after read
// RULE3 - Software never sets three start bits together
// RULE4 - Processor stalled while any operation runs
// RULE5 - Key 55h in reset register resets chip
// RULE6 - Buffer clear bit self-clears when done
// RULE7 - Successful unlock sets program unlock status
// RULE8 - Tagging write increments address, saturates at 31
// RULE9 - Erase covers tagged page locations only
// RULE10 - Unlock trigger under code 110 starts timer
// RULE11 - Software writes six key bytes while timing
// RULE12 - Timer expiry clears unlock trigger always
// RULE13 - Wrong key leaves erase and write disabled
// RULE14 - Clearing unlock status disables programming at once
// RULE15 - Buffer holds 32 words, page bits 12:5
// RULE16 - High byte write advances buffer, saturating
// RULE17 - Code 001 start erases tagged page
// RULE18 - Code 000 start programs buffered words
// RULE19 - Software checks unlock status before programming
// RULE20 - Software blank checks erased page, retries
// RULE21 - Software clears buffer and reprograms on failure
// RULE22 - First data high write loads buffer, bumps address
// RULE23 - Write start bit clears when operation finishes
// RULE24 - Software cannot set unlock status directly
// RULE25 - Read result lands in first data pair
// RULE26 - Erase or program ignored while locked
`ifndef IAP_FLASH_DEFINES_VH
`define IAP_FLASH_DEFINES_VH
// ====================================================
// Register word offsets (byte address = 4 * index)
`define REG_CTRL        4'h0
`define REG_RST_KEY     4'h1
`define REG_BUF_CLR     4'h2
`define REG_ADDR_LO     4'h3
`define REG_ADDR_HI     4'h4
`define REG_D0_LO       4'h5
`define REG_D0_HI       4'h6
`define REG_D1_LO       4'h7
`define REG_D1_HI       4'h8
`define REG_D2_LO       4'h9
`define REG_D2_HI       4'ha
`define REG_D3_LO       4'hb
`define REG_D3_HI       4'hc
// ====================================================
// Control register fields
`define CTRL_RD_START   0
`define CTRL_RD_PERMIT  1
`define CTRL_WR_START   2
`define CTRL_UNL_TRIG   3
`define CTRL_OP_LSB     4
`define CTRL_UNL_STAT   7
`define OP_PROGRAM      3'h0
`define OP_ERASE        3'h1
`define OP_READ         3'h3
`define OP_UNLOCK       3'h6
`define RESET_KEY       8'h55
`define KEY_D1_LO       8'h00
`define KEY_D2_LO       8'h0d
`define KEY_D3_LO       8'hc3
`define KEY_D1_HI       8'h04
`define KEY_D2_HI       8'h09
`define KEY_D3_HI       8'h40
`define ERASED_WORD     16'h0000
`define PAGE_LAST       5'h1f
// ====================================================
// Timing
`define CLK_MHZ         50
`define RD_CYCLES       3
`define UNLOCK_US       1000
`define UNLOCK_CYCLES   (`UNLOCK_US * `CLK_MHZ)
`define OP_US           2000
`define OP_CYCLES       (`OP_US * `CLK_MHZ)
`endif

// >>> core/iap_page_buffer.v
`timescale 1ns/1ps
// ====================================================
// Page write buffer: 32 words with registered read and one-word-per-cycle clear.
module iap_page_buffer #(
   parameter WIDTH = 16,
   parameter AW    = 5
) (
   // Clock.
   input  wire             ref_clk_in,
   // Write port.
   input  wire             wr_en_in,
   input  wire [AW-1:0]    wr_addr_in,
   input  wire [WIDTH-1:0] wr_data_in,
   // Read port.
   input  wire [AW-1:0]    rd_addr_in,
   output reg  [WIDTH-1:0] rd_data_out
);
   reg [WIDTH-1:0] mem [0:(1<<AW)-1];

   // Storage array; read data registered to suit block memory.
   always @(posedge ref_clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule

// >>> core/iap_countdown.v
`timescale 1ns/1ps
// ====================================================
// Loadable down counter; done pulses one cycle as it reaches zero.
module iap_countdown #(
   parameter W = 24
) (
   // Clock and reset.
   input  wire         ref_clk_in,
   input  wire         sys_rst_in,
   // Control.
   input  wire         load_in,
   input  wire [W-1:0] count_in,
   input  wire         abort_in,
   // Status.
   output reg          busy_out,
   output reg          done_out
);
   reg [W-1:0] remain;

   // Load wins over abort so a restart is never lost.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         remain   <= {W{1'b0}};
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (load_in) begin
            remain   <= count_in;
            busy_out <= 1'b1;
         end else if (abort_in) begin
            busy_out <= 1'b0;
         end else if (busy_out) begin
            if (remain <= {{(W-1){1'b0}}, 1'b1}) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end else begin
               remain <= remain - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// >>> core/iap_flash_program_control.v
`timescale 1ns/1ps
`include "iap_flash_defines.vh"
// ====================================================
// In-application programming controller with Avalon-MM register slave.
// The flash array itself is outside; this block issues read, erase and program strobes.
module iap_flash_program_control #(
   parameter UNLOCK_CYCLES = `UNLOCK_CYCLES,
   parameter OP_CYCLES     = `OP_CYCLES
) (
   // Clock and reset.
   input  wire        ref_clk_in,
   input  wire        sys_rst_in,
   // Avalon-MM slave.
   input  wire [5:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   input  wire [3:0]  avs_byteenable_in,
   output reg  [31:0] avs_readdata_out,
   output reg         avs_waitrequest_out,
   // Flash array side.
   output reg  [12:0] flash_addr_out,
   output reg         flash_read_out,
   input  wire [15:0] flash_rdata_in,
   output reg         flash_erase_out,
   output reg  [31:0] erase_tag_out,
   output reg         flash_prog_out,
   output reg  [15:0] flash_wdata_out,
   // System.
   output reg         cpu_stall_out,
   output reg         chip_reset_out
);
   // ====================================================
   // States of the operation sequencer.
   localparam ST_IDLE  = 4'b0001;
   localparam ST_READ  = 4'b0010;
   localparam ST_TIMED = 4'b0100;
   localparam ST_CLEAR = 4'b1000;

   reg  [3:0]  state;
   reg         rd_permit;
   reg         rd_start;
   reg         wr_start;
   reg         unl_trig;
   reg         unl_stat;
   reg  [2:0]  op_sel;
   reg  [7:0]  reset_key;
   reg         buf_clr;
   reg  [12:0] addr;
   reg  [7:0]  dlo [0:3];
   reg  [7:0]  dhi [0:3];
   reg  [31:0] tag;
   reg  [31:0] valid;
   reg  [4:0]  idx;
   reg  [1:0]  rd_cnt;
   reg         is_prog;
   reg         prog_go;
   reg  [4:0]  idx_q;
   reg  [3:0]  bus_index;
   reg  [7:0]  rdata;
   reg         buf_we;
   reg  [4:0]  buf_waddr;
   reg  [15:0] buf_wdata;
   wire [15:0] buf_q;
   wire        unl_done;
   wire        op_busy;
   wire        op_done;
   wire [7:0]  wbyte;
   wire        wr_hit;
   wire        key_ok;

   assign wbyte  = avs_writedata_in[7:0];
   assign wr_hit = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
   assign key_ok = dlo[1] == `KEY_D1_LO && dlo[2] == `KEY_D2_LO && dlo[3] == `KEY_D3_LO &&
                   dhi[1] == `KEY_D1_HI && dhi[2] == `KEY_D2_HI && dhi[3] == `KEY_D3_HI;

   // ====================================================
   // Unlock window timer.
   iap_countdown #(.W(32)) unlock_timer (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .load_in    (wr_hit && bus_index == `REG_CTRL && wbyte[`CTRL_UNL_TRIG] && !unl_trig &&
                   wbyte[`CTRL_OP_LSB+2:`CTRL_OP_LSB] == `OP_UNLOCK), // RULE10
      .count_in   (UNLOCK_CYCLES),
      .abort_in   (1'b0),
      .busy_out   (),
      .done_out   (unl_done)
   );

   // Erase and program duration timer.
   iap_countdown #(.W(32)) op_timer (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .load_in    (state == ST_IDLE && wr_start),
      .count_in   (OP_CYCLES),
      .abort_in   (1'b0),
      .busy_out   (op_busy),
      .done_out   (op_done)
   );

   // ====================================================
   // Page write buffer; program phase walks it by index.
   iap_page_buffer #(.WIDTH(16), .AW(5)) page_buf (
      .ref_clk_in  (ref_clk_in),
      .wr_en_in    (buf_we),
      .wr_addr_in  (buf_waddr),
      .wr_data_in  (buf_wdata),
      .rd_addr_in  (idx),
      .rd_data_out (buf_q)
   );

   // Read mux for the byte-wide registers; upper bytes read zero.
   always @* begin
      rdata = 8'h00;
      case (avs_address_in[5:2])
         `REG_CTRL:    rdata = {unl_stat, op_sel, unl_trig, wr_start, rd_permit, rd_start};
         `REG_RST_KEY: rdata = reset_key;
         `REG_BUF_CLR: rdata = {7'h00, buf_clr};
         `REG_ADDR_LO: rdata = addr[7:0];
         `REG_ADDR_HI: rdata = {3'h0, addr[12:8]};
         `REG_D0_LO:   rdata = dlo[0];
         `REG_D0_HI:   rdata = dhi[0];
         `REG_D1_LO:   rdata = dlo[1];
         `REG_D1_HI:   rdata = dhi[1];
         `REG_D2_LO:   rdata = dlo[2];
         `REG_D2_HI:   rdata = dhi[2];
         `REG_D3_LO:   rdata = dlo[3];
         `REG_D3_HI:   rdata = dhi[3];
         default:      rdata = 8'h00;
      endcase
   end

   // ====================================================
   // Bus handshake: every access stalls at least one cycle, then completes.
   // Reads and writes arriving while the processor is stalled are held off, matching the halted core.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0000_0000;
         bus_index           <= 4'h0;
      end else begin
         bus_index <= avs_address_in[5:2];
         if ((avs_read_in || avs_write_in) && avs_waitrequest_out && !cpu_stall_out) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out    <= {24'h000000, rdata};
         end else begin
            avs_waitrequest_out <= 1'b1;
         end
      end
   end

   // ====================================================
   // Register file and sequencer; writes are applied on the completing edge.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         state <= ST_IDLE;
         rd_permit <= 1'b0;
         rd_start <= 1'b0;
         wr_start <= 1'b0;
         unl_trig <= 1'b0;
         unl_stat <= 1'b0;
         op_sel <= 3'h0;
         reset_key <= 8'h00;
         buf_clr <= 1'b0;
         addr <= 13'h0000;
         dlo[0] <= 8'h00; dlo[1] <= 8'h00; dlo[2] <= 8'h00; dlo[3] <= 8'h00;
         dhi[0] <= 8'h00; dhi[1] <= 8'h00; dhi[2] <= 8'h00; dhi[3] <= 8'h00;
         tag <= 32'h0000_0000;
         valid <= 32'h0000_0000;
         idx <= 5'h00;
         rd_cnt <= 2'h0;
         is_prog <= 1'b0;
         prog_go <= 1'b0;
         idx_q <= 5'h00;
         buf_we <= 1'b0;
         buf_waddr <= 5'h00;
         buf_wdata <= 16'h0000;
         flash_addr_out <= 13'h0000;
         flash_read_out <= 1'b0;
         flash_erase_out <= 1'b0;
         erase_tag_out <= 32'h0000_0000;
         flash_prog_out <= 1'b0;
         flash_wdata_out <= 16'h0000;
         cpu_stall_out <= 1'b0;
         chip_reset_out <= 1'b0;
      end else begin
         buf_we <= 1'b0;
         flash_read_out <= 1'b0;
         flash_erase_out <= 1'b0;
         flash_prog_out <= 1'b0;
         chip_reset_out <= 1'b0;
         prog_go <= 1'b0;
         if (wr_hit) begin
            case (bus_index)
               `REG_CTRL: begin
                  op_sel    <= wbyte[`CTRL_OP_LSB+2:`CTRL_OP_LSB];
                  rd_permit <= wbyte[`CTRL_RD_PERMIT];
                  if (!wbyte[`CTRL_UNL_STAT]) begin
                     unl_stat <= 1'b0; // RULE14 RULE24
                  end
                  if (wbyte[`CTRL_UNL_TRIG] && wbyte[`CTRL_OP_LSB+2:`CTRL_OP_LSB] == `OP_UNLOCK) begin
                     unl_trig <= 1'b1; // RULE10
                  end
                  // Reads need read mode and permission in the same write as the start bit.
                  rd_start <= wbyte[`CTRL_RD_START] && wbyte[`CTRL_RD_PERMIT] &&
                              wbyte[`CTRL_OP_LSB+2:`CTRL_OP_LSB] == `OP_READ; // RULE1
                  wr_start <= wbyte[`CTRL_WR_START] && unl_stat && wbyte[`CTRL_UNL_STAT] &&
                              (wbyte[`CTRL_OP_LSB+2:`CTRL_OP_LSB] == `OP_ERASE ||
                               wbyte[`CTRL_OP_LSB+2:`CTRL_OP_LSB] == `OP_PROGRAM); // RULE26 RULE17 RULE18
               end
               `REG_RST_KEY: begin
                  reset_key <= wbyte;
                  chip_reset_out <= (wbyte == `RESET_KEY); // RULE5
               end
               `REG_BUF_CLR: begin
                  buf_clr <= wbyte[0]; // RULE6
               end
               `REG_ADDR_LO: addr[7:0] <= wbyte;
               `REG_ADDR_HI: addr[12:8] <= wbyte[4:0];
               `REG_D0_LO:   dlo[0] <= wbyte;
               `REG_D0_HI: begin
                  dhi[0] <= wbyte;
                  // Load the word and tag the offset, then step within the page.
                  buf_we    <= 1'b1; // RULE22
                  buf_waddr <= addr[4:0]; // RULE15
                  buf_wdata <= {wbyte, dlo[0]};
                  tag[addr[4:0]]   <= 1'b1; // RULE9
                  valid[addr[4:0]] <= 1'b1;
                  if (addr[4:0] != `PAGE_LAST) begin
                     addr <= addr + 13'h0001; // RULE8 RULE16
                  end
               end
               `REG_D1_LO: dlo[1] <= wbyte; // RULE11
               `REG_D1_HI: dhi[1] <= wbyte;
               `REG_D2_LO: dlo[2] <= wbyte;
               `REG_D2_HI: dhi[2] <= wbyte;
               `REG_D3_LO: dlo[3] <= wbyte;
               `REG_D3_HI: dhi[3] <= wbyte;
               default: begin
               end
            endcase
         end
         // Timer expiry drops the trigger and judges the key; placed after the writes so hardware wins a tie.
         if (unl_done) begin
            unl_trig <= 1'b0; // RULE12
            if (key_ok) begin
               unl_stat <= 1'b1; // RULE7
            end // RULE13
         end
         // Operation sequencer.
         case (state)
            ST_IDLE: begin
               if (rd_start && rd_permit) begin
                  state <= ST_READ;
                  cpu_stall_out <= 1'b1; // RULE4
                  flash_addr_out <= addr;
                  flash_read_out <= 1'b1;
                  rd_cnt <= 2'h0;
               end else if (wr_start) begin
                  state <= ST_TIMED;
                  cpu_stall_out <= 1'b1; // RULE4
                  is_prog <= (op_sel == `OP_PROGRAM);
                  flash_addr_out <= addr;
                  idx <= 5'h00;
                  if (op_sel == `OP_ERASE) begin
                     flash_erase_out <= 1'b1; // RULE17
                     erase_tag_out <= tag;
                  end
               end else if (buf_clr) begin
                  state <= ST_CLEAR;
                  idx <= 5'h00;
               end
            end
            ST_READ: begin
               rd_cnt <= rd_cnt + 2'h1;
               if (rd_cnt == `RD_CYCLES - 1) begin
                  dlo[0] <= flash_rdata_in[7:0]; // RULE25
                  dhi[0] <= flash_rdata_in[15:8];
                  rd_start <= 1'b0; // RULE2
                  cpu_stall_out <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            ST_TIMED: begin
               // Program walks the page once; the strobe lags the index by the buffer's read register.
               if (is_prog && op_busy) begin
                  idx <= idx + 5'h01;
                  idx_q <= idx;
                  prog_go <= valid[idx];
                  is_prog <= (idx != `PAGE_LAST);
               end
               if (prog_go) begin
                  flash_prog_out <= 1'b1; // RULE18
                  flash_addr_out <= {addr[12:5], idx_q}; // RULE15
                  flash_wdata_out <= buf_q;
               end
               if (op_done) begin
                  wr_start <= 1'b0; // RULE23
                  cpu_stall_out <= 1'b0;
                  tag <= 32'h0000_0000;
                  state <= ST_IDLE;
               end
            end
            ST_CLEAR: begin
               buf_we <= 1'b1;
               buf_waddr <= idx;
               buf_wdata <= 16'h0000;
               idx <= idx + 5'h01;
               if (idx == `PAGE_LAST) begin
                  valid <= 32'h0000_0000;
                  tag <= 32'h0000_0000;
                  buf_clr <= 1'b0; // RULE6
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule

// >>> test/flash_array_model.sv
`timescale 1ns/1ps
// ==============================
// Flash array stand-in: cells start at a pattern the bench can recompute.
module flash_array_model (
   // Clock.
   input  wire         ref_clk_in,
   // Strobes from the controller.
   input  wire  [12:0] flash_addr_in,
   input  wire         flash_read_in,
   input  wire         flash_erase_in,
   input  wire  [31:0] erase_tag_in,
   input  wire         flash_prog_in,
   input  wire  [15:0] flash_wdata_in,
   // Data back to the controller.
   output logic [15:0] flash_rdata_out
);
   logic [15:0] mem [0:8191];
   logic [2:0]  rd_win = 3'h0;
   logic [15:0] noise  = 16'h0000;
   // Initial contents.
   initial for (int i = 0; i < 8192; i++) mem[i] = 16'(i * 5 + 3);
   // Erase clears only tagged cells of the addressed page.
   always @(posedge ref_clk_in) begin
      rd_win <= {rd_win[1:0], flash_read_in};
      noise <= noise + 16'h3b1d;
      if (flash_prog_in) mem[flash_addr_in] <= flash_wdata_in;
      if (flash_erase_in) begin
         for (int i = 0; i < 32; i++) if (erase_tag_in[i]) mem[{flash_addr_in[12:5], 5'(i)}] <= 16'h0000;
      end
   end
   // Outside a read the data lines change every cycle, so stale data cannot pass.
   assign flash_rdata_out = (flash_read_in | (|rd_win)) ? mem[flash_addr_in] : noise;
endmodule

// >>> test/iap_flash_program_control_chk.sv
`timescale 1ns/1ps
// ==============================
// Checker on the controller's ports.
module iap_flash_program_control_chk (
   // Clock and reset.
   input wire        ref_clk_in,
   input wire        sys_rst_in,
   // Register bus.
   input wire [5:0]  avs_address_in,
   input wire        avs_read_in,
   input wire        avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0]  avs_byteenable_in,
   input wire [31:0] avs_readdata_out,
   input wire        avs_waitrequest_out,
   // Flash side.
   input wire [12:0] flash_addr_out,
   input wire        flash_read_out,
   input wire [15:0] flash_rdata_in,
   input wire        flash_erase_out,
   input wire [31:0] erase_tag_out,
   input wire        flash_prog_out,
   input wire [15:0] flash_wdata_out,
   // System.
   input wire        cpu_stall_out,
   input wire        chip_reset_out
);
   logic       wr_done;
   logic       key_wr;
   logic       rd_req;
   logic [2:0] rd_req_q;
   // Writes completing at this edge.
   assign wr_done = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
   assign key_wr  = wr_done & (avs_address_in[5:2] == 4'h1) & (avs_writedata_in[7:0] == 8'h55);
   assign rd_req  = wr_done & (avs_address_in[5:2] == 4'h0) & (avs_writedata_in[6:0] == 7'h33);
   // Recent read launches by software; a strobe without one is a fault.
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) rd_req_q <= 3'h0;
      else rd_req_q <= {rd_req_q[1:0], rd_req};
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_read_permit: assert property ($rose(flash_read_out) |-> (|rd_req_q))
      else $error("read strobe without permitted start");
   a_read_stall: assert property ($rose(flash_read_out) |-> ##1 cpu_stall_out)
      else $error("read did not stall the core");
   a_bus_frozen: assert property (cpu_stall_out |-> avs_waitrequest_out)
      else $error("bus answered while stalled");
   a_read_done: assert property ($rose(flash_read_out) |-> ##[1:8] !cpu_stall_out)
      else $error("read never finished");
   a_op_done: assert property (($rose(flash_erase_out) || $rose(flash_prog_out)) |-> ##[1:400] !cpu_stall_out)
      else $error("erase or program never finished");
   a_erase_stall: assert property (flash_erase_out |=> cpu_stall_out)
      else $error("erase did not hold the stall");
   a_key_reset: assert property (key_wr |-> ##[1:2] chip_reset_out)
      else $error("reset key gave no chip reset");
   a_reset_cause: assert property (chip_reset_out |-> ($past(key_wr) || $past(key_wr, 2)))
      else $error("chip reset without reset key");
   c_read: cover property ($rose(flash_read_out));
   c_erase: cover property (flash_erase_out);
   c_chip_reset: cover property (chip_reset_out);
endmodule
bind iap_flash_program_control iap_flash_program_control_chk i_chk (
   .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
   .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .flash_addr_out(flash_addr_out),
   .flash_read_out(flash_read_out), .flash_rdata_in(flash_rdata_in), .flash_erase_out(flash_erase_out),
   .erase_tag_out(erase_tag_out), .flash_prog_out(flash_prog_out), .flash_wdata_out(flash_wdata_out),
   .cpu_stall_out(cpu_stall_out), .chip_reset_out(chip_reset_out)
);

// >>> test/tb_iap_flash_program_control.sv
`timescale 1ns/1ps
// ==============================
// Self-checking bench for the programming controller.
module tb_iap_flash_program_control;
   logic        ref_clk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic [5:0]  avs_address_in = 6'h00;
   logic        avs_read_in = 1'b0;
   logic        avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0]  avs_byteenable_in = 4'h0;
   wire  [31:0] avs_readdata_out, erase_tag_out;
   wire  [12:0] flash_addr_out;
   wire  [15:0] flash_rdata_in, flash_wdata_out;
   wire         avs_waitrequest_out, flash_read_out, flash_erase_out, flash_prog_out, cpu_stall_out, chip_reset_out;
   int          fails = 0;
   int          samples_checked = 0;
   int          n_rd = 0;
   int          n_er = 0;
   int          n_rst = 0;
   logic [31:0] q, tag_seen;
   logic [28:0] prog_q [$];
   logic [15:0] model [int];
   iap_flash_program_control #(.UNLOCK_CYCLES(60), .OP_CYCLES(40)) i_iap_flash_program_control (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .flash_addr_out(flash_addr_out),
      .flash_read_out(flash_read_out), .flash_rdata_in(flash_rdata_in), .flash_erase_out(flash_erase_out),
      .erase_tag_out(erase_tag_out), .flash_prog_out(flash_prog_out), .flash_wdata_out(flash_wdata_out),
      .cpu_stall_out(cpu_stall_out), .chip_reset_out(chip_reset_out));
   flash_array_model i_flash_array_model (
      .ref_clk_in(ref_clk_in), .flash_addr_in(flash_addr_out), .flash_read_in(flash_read_out),
      .flash_erase_in(flash_erase_out), .erase_tag_in(erase_tag_out), .flash_prog_in(flash_prog_out),
      .flash_wdata_in(flash_wdata_out), .flash_rdata_out(flash_rdata_in));
   // A 50 MHz clock.
   always #10 ref_clk_in = ~ref_clk_in;
   // Count strobes and record what reaches the array.
   always @(posedge ref_clk_in) begin
      if (flash_read_out) n_rd++;
      if (flash_erase_out) n_er++;
      if (flash_erase_out) tag_seen = erase_tag_out;
      if (chip_reset_out) n_rst++;
      if (flash_prog_out) prog_q.push_back({flash_addr_out, flash_wdata_out});
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus access; the request is held until waitrequest is seen low.
   task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_in);
      avs_address_in <= {idx, 2'b00};
      avs_write_in <= w;
      avs_read_in <= ~w;
      avs_writedata_in <= {24'h0, d};
      avs_byteenable_in <= 4'h1;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 400);
      if (n >= 400) fails++;
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      chk(q, {24'h0, e});
   endtask
   task automatic setaddr(input logic [12:0] a);
      bus(1'b1, 4'h3, a[7:0]);
      bus(1'b1, 4'h4, {3'h0, a[12:8]});
   endtask
   // Poll a register until the masked bits clear, with a bounded count.
   task automatic waitclr(input logic [3:0] idx, input logic [7:0] m);
      int n;
      n = 0;
      do begin
         bus(1'b0, idx, 8'h00);
         n++;
      end while ((q[7:0] & m) != 8'h00 && n < 100);
      if ((q[7:0] & m) !== 8'h00) fails++;
   endtask
   task automatic flread(input logic [12:0] a, input logic ul);
      logic [15:0] w;
      w = model.exists(int'(a)) ? model[int'(a)] : 16'(a * 5 + 3);
      setaddr(a);
      bus(1'b1, 4'h0, {ul, 7'h33});
      waitclr(4'h0, 8'h01);
      rdc(4'h5, w[7:0]);
      rdc(4'h6, w[15:8]);
   endtask
   task automatic unlock(input logic bad);
      logic [7:0] kv [6];
      logic [3:0] ki [6];
      kv = '{8'h00, 8'h0d, 8'hc3, 8'h04, 8'h09, 8'h40};
      ki = '{4'h7, 4'h9, 4'hb, 4'h8, 4'ha, 4'hc};
      if (bad) kv[$urandom_range(5)] ^= 8'(1 + $urandom_range(254));
      bus(1'b1, 4'h0, 8'h68);
      for (int i = 0; i < 6; i++) bus(1'b1, ki[i], kv[i]);
      waitclr(4'h0, 8'h08);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog sized well above the expected run of several hundred cycles.
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      fails++;
      complete_run();
   end
   initial begin
      logic [7:0]  k, pg;
      logic [15:0] ws [32];
      void'($urandom(29395));
      repeat (12) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rdc(4'h0, 8'h00);
      rdc(4'h1, 8'h00);
      rdc(4'h2, 8'h00);
      rdc(4'hd, 8'h00);
      k = 8'($urandom);
      if (k == 8'h55) k = 8'h54;
      bus(1'b1, 4'h1, k);
      rdc(4'h1, k);
      bus(1'b1, 4'h1, 8'h55);
      repeat (3) @(posedge ref_clk_in);
      chk(n_rst, 1);
      // The chip reset comes back around as a system reset in mid-run.
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rdc(4'h1, 8'h00);
      setaddr(13'($urandom));
      bus(1'b1, 4'h0, 8'h31);
      flread(13'($urandom), 1'b0);
      chk(n_rd, 1);
      rdc(4'h0, 8'h32);
      bus(1'b1, 4'h0, 8'h14);
      unlock(1'b1);
      chk(q, 32'h60);
      chk(n_er, 0);
      bus(1'b1, 4'h0, 8'h80);
      rdc(4'h0, 8'h00);
      unlock(1'b0);
      chk(q, 32'he0);
      pg = 8'($urandom);
      bus(1'b1, 4'h0, 8'h90);
      bus(1'b1, 4'h2, 8'h01);
      waitclr(4'h2, 8'h01);
      chk(q, 32'h0);
      setaddr({pg, 5'd30});
      repeat (3) bus(1'b1, 4'h6, 8'h00);
      rdc(4'h3, {pg[2:0], 5'h1f});
      bus(1'b1, 4'h0, 8'h94);
      waitclr(4'h0, 8'h04);
      chk(q, 32'h90);
      chk(tag_seen, 32'hc000_0000);
      model[int'({pg, 5'd30})] = 16'h0000;
      model[int'({pg, 5'd31})] = 16'h0000;
      flread({pg, 5'd31}, 1'b1);
      flread({pg, 5'd29}, 1'b1);
      bus(1'b1, 4'h0, 8'h80);
      bus(1'b1, 4'h2, 8'h01);
      waitclr(4'h2, 8'h01);
      setaddr({pg, 5'd29});
      for (int i = 0; i < 4; i++) begin
         k = (i < 2) ? 8'(29 + i) : 8'd31;
         ws[k] = 16'($urandom);
         bus(1'b1, 4'h5, ws[k][7:0]);
         bus(1'b1, 4'h6, ws[k][15:8]);
      end
      rdc(4'h3, {pg[2:0], 5'h1f});
      prog_q.delete();
      bus(1'b1, 4'h0, 8'h84);
      waitclr(4'h0, 8'h04);
      chk(q, 32'h80);
      chk(prog_q.size(), 3);
      for (int i = 29; i < 32 && prog_q.size() > 0; i++) begin
         chk(prog_q.pop_front(), {pg, 5'(i), ws[i]});
         model[int'({pg, 5'(i)})] = ws[i];
      end
      flread({pg, 5'd30}, 1'b1);
      bus(1'b1, 4'h0, 8'h04);
      rdc(4'h0, 8'h00);
      chk(prog_q.size(), 0);
      complete_run();
   end
endmodule
